// ### src/pcoc_pkg.sv
// Function
// - output clock is built from and aligned to the system clock
// - clock-out enable picks pin function: clock when 1, plain I/O when 0
// - source is timer-zero match frequency halved or a divided system clock
// - prescale field bits 3..2; code 00 passes the system clock undivided
// - sleep mode stops the output clock regardless of enable
// - mode 000/001/010: SPI master at system clock /4, /16, /64
// - mode 011: SPI master on time-base clock; 100: timer-zero match /2
// - mode 101 SPI slave, 110 I2C slave, 111 unused
// - serial enable bit 1 switches interface; off floats lines, low current
// - serial enable has effect only when the configuration option allows it
// - rising serial enable leaves SPI control contents unknown; software inits
package pcoc_pkg;
    localparam logic [11:0] PCOC_CTRL_ADDR = 12'h000;
    localparam logic [7:0]  PCOC_CTRL_RESET = 8'hE0;
    localparam int          PCOC_MODE_LSB = 5;
    localparam int          PCOC_CKEN_BIT = 4;
    localparam int          PCOC_PRESC_LSB = 2;
    localparam int          PCOC_SEN_BIT = 1;
    localparam logic [7:0]  PCOC_WRITE_MASK = 8'hFE;
    // divisors for prescale codes 01 and 10 (even values, halved into half-period counts)
    localparam logic [7:0]  PCOC_DIV_CODE1 = 8'h04;
    localparam logic [7:0]  PCOC_DIV_CODE2 = 8'h08;
    localparam logic [1:0]  PCOC_PRESC_SYS = 2'h0;
    localparam logic [1:0]  PCOC_PRESC_D1 = 2'h1;
    localparam logic [1:0]  PCOC_PRESC_D2 = 2'h2;
    localparam logic [1:0]  PCOC_PRESC_TMR = 2'h3;
    typedef enum logic [2:0] {
        PCOC_SPI_M_DIV4  = 3'h0,
        PCOC_SPI_M_DIV16 = 3'h1,
        PCOC_SPI_M_DIV64 = 3'h2,
        PCOC_SPI_M_TBC   = 3'h3,
        PCOC_SPI_M_TMR   = 3'h4,
        PCOC_SPI_SLAVE   = 3'h5,
        PCOC_I2C_SLAVE   = 3'h6,
        PCOC_UNUSED      = 3'h7
    } pcoc_mode_e;
    localparam logic [5:0] PCOC_SCK_DIV4 = 6'h01;
    localparam logic [5:0] PCOC_SCK_DIV16 = 6'h07;
    localparam logic [5:0] PCOC_SCK_DIV64 = 6'h1F;
endpackage

// ### src/pcoc_divider.sv
`timescale 1ns/1ps
// toggles its output every (half_count+1) cycles; restarts low when cleared
module pcoc_divider (
    input  wire logic       sys_clk,
    input  wire logic       rstn,
    input  wire logic       run,
    input  wire logic [7:0] half_count,
    output logic            clk_out
);
    logic [7:0] cnt_reg;
    wire        wrap = (cnt_reg >= half_count);
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            cnt_reg <= 8'h00;
            clk_out <= 1'b0;
        end else if (!run) begin
            cnt_reg <= 8'h00;
            clk_out <= 1'b0;
        end else if (wrap) begin
            cnt_reg <= 8'h00;
            clk_out <= ~clk_out;
        end else begin
            cnt_reg <= cnt_reg + 8'h01;
        end
    end
endmodule

// ### src/pcoc_top.sv
// Register access over APB and the register offsets were decided locally.
`timescale 1ns/1ps
module pcoc_top (
    input  wire logic        sys_clk,
    input  wire logic        rstn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic [31:0]      prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic        sleep_mode,
    input  wire logic        serial_config_option,
    input  wire logic        timer_zero_match,
    input  wire logic        time_base_clock,
    input  wire logic        gpio_out,
    input  wire logic        gpio_oe_n,
    output logic             periph_clock_out_pin_o,
    output logic             periph_clock_out_pin_oe_n,
    output logic [2:0]       serial_mode,
    output logic             serial_enabled,
    output logic             serial_lines_float,
    output logic             spi_master_sel,
    output logic             spi_slave_sel,
    output logic             i2c_slave_sel,
    output logic             spi_clock_gen,
    output logic             spi_ctrl_unknown
);
    logic [7:0] ctrl_reg;
    logic [7:0] ctrl_next;
    logic       tmr_half_reg;
    logic       sen_eff_reg;
    logic       clk_out_reg;
    logic       spi_clk_reg;
    logic [5:0] sck_cnt_reg;
    logic       unk_reg;
    logic [7:0] rdata_byte;

    wire        addr_hit = (paddr == pcoc_pkg::PCOC_CTRL_ADDR);
    wire        wr_en = psel && penable && pwrite && addr_hit;
    wire [2:0]  mode = ctrl_reg[pcoc_pkg::PCOC_MODE_LSB +: 3];
    wire        cken = ctrl_reg[pcoc_pkg::PCOC_CKEN_BIT];
    wire [1:0]  presc = ctrl_reg[pcoc_pkg::PCOC_PRESC_LSB +: 2];
    wire        sen_bit = ctrl_reg[pcoc_pkg::PCOC_SEN_BIT];
    wire        sen_eff = sen_bit && serial_config_option;
    wire        out_run = cken && !sleep_mode;
    wire        div_run = out_run && (presc == pcoc_pkg::PCOC_PRESC_D1 ||
                                      presc == pcoc_pkg::PCOC_PRESC_D2);
    wire [7:0]  div_half = (presc == pcoc_pkg::PCOC_PRESC_D1) ?
                           (pcoc_pkg::PCOC_DIV_CODE1 >> 1) - 8'h01 :
                           (pcoc_pkg::PCOC_DIV_CODE2 >> 1) - 8'h01;
    wire        div_clk;
    logic       src_clk;

    // bit 0 never stored, so it reads back 0
    assign ctrl_next = (pwdata[7:0] & pcoc_pkg::PCOC_WRITE_MASK);
    assign rdata_byte = ctrl_reg;
    assign pready = 1'b1;
    assign pslverr = psel && penable && !addr_hit;

    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            ctrl_reg <= pcoc_pkg::PCOC_CTRL_RESET;
        end else if (wr_en) begin
            ctrl_reg <= ctrl_next;
        end
    end

    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            prdata <= 32'h0000_0000;
        end else if (psel && !penable && !pwrite) begin
            prdata <= addr_hit ? {24'h000000, rdata_byte} : 32'h0000_0000;
        end
    end

    // timer-zero match pulses halved by a toggle
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            tmr_half_reg <= 1'b0;
        end else if (timer_zero_match) begin
            tmr_half_reg <= ~tmr_half_reg;
        end
    end

    pcoc_divider u_div (
        .sys_clk    (sys_clk),
        .rstn       (rstn),
        .run        (div_run),
        .half_count (div_half),
        .clk_out    (div_clk)
    );

    // code 00 cannot be retimed by a flop; it gates the system clock itself,
    // which is aligned but glitch-prone if enable changes while sys_clk is high
    always_comb begin
        case (presc)
            pcoc_pkg::PCOC_PRESC_SYS: src_clk = sys_clk;
            pcoc_pkg::PCOC_PRESC_TMR: src_clk = tmr_half_reg;
            default:                  src_clk = div_clk;
        endcase
    end

    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            clk_out_reg <= 1'b0;
        end else begin
            clk_out_reg <= out_run && (presc == pcoc_pkg::PCOC_PRESC_TMR) ?
                           tmr_half_reg : div_clk;
        end
    end

    assign periph_clock_out_pin_o = !out_run ? gpio_out :
        (presc == pcoc_pkg::PCOC_PRESC_SYS) ? src_clk : clk_out_reg;
    assign periph_clock_out_pin_oe_n = out_run ? 1'b0 : gpio_oe_n;

    // serial mode decode
    assign serial_mode = mode;
    assign spi_master_sel = sen_eff && (mode <= 3'(pcoc_pkg::PCOC_SPI_M_TMR));
    assign spi_slave_sel = sen_eff && (mode == 3'(pcoc_pkg::PCOC_SPI_SLAVE));
    assign i2c_slave_sel = sen_eff && (mode == 3'(pcoc_pkg::PCOC_I2C_SLAVE));
    assign serial_enabled = sen_eff;
    assign serial_lines_float = !sen_eff;
    assign spi_ctrl_unknown = unk_reg;

    // serial clock for master modes; slave mode relies on the external clock
    wire [5:0] sck_half =
        (mode == 3'(pcoc_pkg::PCOC_SPI_M_DIV4))  ? pcoc_pkg::PCOC_SCK_DIV4 :
        (mode == 3'(pcoc_pkg::PCOC_SPI_M_DIV16)) ? pcoc_pkg::PCOC_SCK_DIV16 :
                                                   pcoc_pkg::PCOC_SCK_DIV64;
    wire       sck_divmode = spi_master_sel && (mode <= 3'(pcoc_pkg::PCOC_SPI_M_DIV64));

    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            sck_cnt_reg <= 6'h00;
            spi_clk_reg <= 1'b0;
        end else begin
            if (!spi_master_sel) begin
                sck_cnt_reg <= 6'h00;
                spi_clk_reg <= 1'b0;
            end else if (sck_divmode) begin
                if (sck_cnt_reg >= sck_half) begin
                    sck_cnt_reg <= 6'h00;
                    spi_clk_reg <= ~spi_clk_reg;
                end else begin
                    sck_cnt_reg <= sck_cnt_reg + 6'h01;
                end
            end else if (mode == 3'(pcoc_pkg::PCOC_SPI_M_TBC)) begin
                spi_clk_reg <= time_base_clock;
            end else begin
                spi_clk_reg <= tmr_half_reg;
            end
        end
    end
    assign spi_clock_gen = spi_clk_reg;

    // flags that SPI control contents are not valid after enable rises
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            sen_eff_reg <= 1'b0;
            unk_reg <= 1'b0;
        end else begin
            sen_eff_reg <= sen_eff;
            if (sen_eff && !sen_eff_reg) begin
                unk_reg <= 1'b1;
            end else if (!sen_eff) begin
                unk_reg <= 1'b0;
            end
        end
    end
endmodule

// ### testbench/pcoc_checker.sv
`timescale 1ns/1ps
module pcoc_checker (
    input wire logic        sys_clk,
    input wire logic        rstn,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic        sleep_mode,
    input wire logic        serial_config_option,
    input wire logic        gpio_oe_n,
    input wire logic        periph_clock_out_pin_oe_n,
    input wire logic [2:0]  serial_mode,
    input wire logic        serial_enabled,
    input wire logic        spi_master_sel,
    input wire logic        spi_slave_sel,
    input wire logic        i2c_slave_sel,
    input wire logic        spi_clock_gen,
    input wire logic        spi_ctrl_unknown
);
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!rstn);
    chk_mode_write: assert property (psel && penable && pwrite && paddr == 12'h000
        |=> serial_mode == $past(pwdata[7:5])) else $error("mode field not written");
    chk_bit0_low: assert property (psel && penable && !pwrite |-> !prdata[0])
        else $error("bit 0 read as one");
    chk_opt_gate: assert property (serial_enabled |-> serial_config_option)
        else $error("enable without option");
    chk_off_nosel: assert property (!serial_enabled |-> !(spi_master_sel || spi_slave_sel
        || i2c_slave_sel)) else $error("select while disabled");
    chk_master_sel: assert property (spi_master_sel == (serial_enabled && serial_mode < 3'h5))
        else $error("master select wrong");
    chk_slave_sel: assert property (spi_slave_sel == (serial_enabled && serial_mode == 3'h5))
        else $error("slave select wrong");
    chk_i2c_sel: assert property (i2c_slave_sel == (serial_enabled && serial_mode == 3'h6))
        else $error("i2c select wrong");
    chk_sleep_off: assert property (sleep_mode && $past(sleep_mode)
        |-> periph_clock_out_pin_oe_n == gpio_oe_n) else $error("clock driven in sleep");
    chk_unknown_set: assert property ($rose(serial_enabled) |-> ##[0:2] spi_ctrl_unknown)
        else $error("unknown flag not set");
    chk_slave_noclk: assert property (spi_slave_sel |=> !spi_clock_gen)
        else $error("serial clock made in slave mode");
endmodule
bind pcoc_top pcoc_checker pcoc_checker_inst (.*);

// ### testbench/pcoc_clock_sink.sv
`timescale 1ns/1ps
// counts clock edges only while the pin is actually driven as a clock
module pcoc_clock_sink (
    input  wire logic pin,
    input  wire logic pin_oe_n,
    output int        edges
);
    initial edges = 0;
    always @(posedge pin) if (pin_oe_n === 1'b0) edges++;
endmodule

// ### testbench/testbench.sv
`timescale 1ns/1ps
`define CHK(n, e, s) begin checked++; if ((s) !== (e)) begin failures++; \
    $display("MISMATCH %s exp %0h got %0h", n, e, s); end end
module testbench;
    logic        sys_clk = 0, rstn = 0, psel = 0, penable = 0, pwrite = 0, slp = 0;
    logic        opt = 1, tm = 0, gout = 0, goe_n = 1, err, pready, pslverr, pin, pin_oe_n;
    logic        sen, sfl, ms, ss, is, unk, sck, tbc = 0;
    logic [11:0] paddr = '0;
    logic [31:0] pwdata = '0, prdata, rd;
    logic [2:0]  smode;
    int          failures = 0, checked = 0, cycles = 0, e0, got, edges, sck_edges;
    int          exp_e [3] = '{40, 40 / pcoc_pkg::PCOC_DIV_CODE1, 40 / pcoc_pkg::PCOC_DIV_CODE2};
    logic [18:0] rows [9] = '{{8'h02, 8'h02, 3'h4}, {8'h23, 8'h22, 3'h4}, {8'h42, 8'h42, 3'h4},
        {8'h62, 8'h62, 3'h4}, {8'h82, 8'h82, 3'h4}, {8'hA2, 8'hA2, 3'h2},
        {8'hC2, 8'hC2, 3'h1}, {8'hE2, 8'hE2, 3'h0}, {8'hFF, 8'hFE, 3'h0}};
    // serial mode against serial clock rises seen in a 64-cycle window
    logic [8:0]  sck_rows [5] = '{{3'h0, 6'h10}, {3'h1, 6'h04}, {3'h2, 6'h01}, {3'h3, 6'h20},
        {3'h5, 6'h00}};
    pcoc_top pcoc_top_inst (.sys_clk(sys_clk), .rstn(rstn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .sleep_mode(slp), .serial_config_option(opt),
        .timer_zero_match(tm), .time_base_clock(tbc), .gpio_out(gout), .gpio_oe_n(goe_n),
        .periph_clock_out_pin_o(pin), .periph_clock_out_pin_oe_n(pin_oe_n),
        .serial_mode(smode), .serial_enabled(sen), .serial_lines_float(sfl),
        .spi_master_sel(ms), .spi_slave_sel(ss), .i2c_slave_sel(is), .spi_clock_gen(sck),
        .spi_ctrl_unknown(unk));
    pcoc_clock_sink pcoc_clock_sink_inst (.pin(pin), .pin_oe_n(pin_oe_n), .edges(edges));
    pcoc_clock_sink pcoc_clock_sink_spi_inst (.pin(sck), .pin_oe_n(1'b0), .edges(sck_edges));
    always #50 sys_clk = ~sys_clk;
    // time-base clock runs at half the system clock throughout
    always @(posedge sys_clk) tbc <= ~tbc;
    task stop_test;
        if (failures == 0 && checked > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask
    task apb(input logic w, input logic [11:0] a, input logic [7:0] d);
        @(posedge sys_clk);
        psel <= 1;
        pwrite <= w;
        paddr <= a;
        pwdata <= {24'h0, d};
        @(posedge sys_clk);
        penable <= 1;
        @(posedge sys_clk);
        while (pready !== 1'b1) @(posedge sys_clk);
        rd = prdata;
        err = pslverr;
        psel <= 0;
        penable <= 0;
    endtask
    task count_edges(input int n);
        @(negedge sys_clk) e0 = edges;
        repeat (n) @(negedge sys_clk);
        got = edges - e0;
    endtask
    always @(posedge sys_clk) begin
        cycles++;
        if (cycles == 5000) begin
            failures++;
            stop_test();
        end
    end
    initial begin
        repeat (4) @(posedge sys_clk);
        rstn <= 1;
        apb(0, 12'h000, 8'h00);
        `CHK("reset", 32'hE0, rd)
        foreach (rows[i]) begin
            apb(1, 12'h000, rows[i][18:11]);
            apb(0, 12'h000, 8'h00);
            `CHK("rdback", {24'h0, rows[i][10:3]}, rd)
            `CHK("mode", rows[i][18:16], smode)
            `CHK("sel", rows[i][2:0], {ms, ss, is})
            `CHK("float", 1'b0, sfl)
        end
        // unmapped write must not disturb the register
        apb(1, 12'h004, 8'h02);
        apb(0, 12'hFFC, 8'h00);
        `CHK("bad", 33'h1_0000_0000, {err, rd})
        apb(0, 12'h000, 8'h00);
        `CHK("kept", 32'hFE, rd)
        apb(1, 12'h000, 8'hE0);
        apb(1, 12'h000, 8'hE2);
        repeat (3) @(posedge sys_clk);
        `CHK("unk", 1'b1, unk)
        apb(1, 12'h000, 8'hE0);
        opt <= 0;
        apb(1, 12'h000, 8'hE2);
        @(negedge sys_clk);
        `CHK("gate", 2'b01, {sen, sfl})
        apb(1, 12'h000, 8'hE0);
        opt <= 1;
        foreach (sck_rows[i]) begin
            apb(1, 12'h000, {sck_rows[i][8:6], 5'h02});
            repeat (8) @(posedge sys_clk);
            @(negedge sys_clk) e0 = sck_edges;
            repeat (64) @(negedge sys_clk);
            `CHK("sck", sck_rows[i][5:0], sck_edges - e0)
        end
        for (int c = 0; c < 3; c++) begin
            apb(1, 12'h000, {4'hF, c[1:0], 2'h0});
            repeat (8) @(posedge sys_clk);
            count_edges(40);
            `CHK("pck", exp_e[c], got)
        end
        apb(1, 12'h000, 8'hFC);
        @(negedge sys_clk) e0 = edges;
        repeat (16) begin
            @(posedge sys_clk) tm <= 1;
            @(posedge sys_clk) tm <= 0;
        end
        repeat (3) @(negedge sys_clk);
        `CHK("tmr", 8, edges - e0)
        apb(1, 12'h000, 8'hF0);
        slp <= 1;
        count_edges(20);
        `CHK("sleep", 34'h2_0000_0000, {pin_oe_n, pin, got})
        @(posedge sys_clk);
        slp <= 0;
        apb(1, 12'h000, 8'hE0);
        gout <= 1;
        @(posedge sys_clk);
        @(negedge sys_clk);
        `CHK("gpio", 2'b11, {pin_oe_n, pin})
        // reset in mid-run with the clock and serial side both active
        apb(1, 12'h000, 8'h12);
        repeat (2) @(posedge sys_clk);
        `CHK("unk set", 1'b1, unk)
        rstn <= 0;
        repeat (2) @(posedge sys_clk);
        rstn <= 1;
        apb(0, 12'h000, 8'h00);
        `CHK("rst2", 32'hE0, rd)
        `CHK("rst2 unk", 1'b0, unk)
        `CHK("rst2 pin", 2'b11, {pin_oe_n, pin})
        stop_test();
    end
endmodule
